/* File: verilog/burst_cfg_pkg.sv */
// Package: constants and types for the burst and timing configuration block
`default_nettype none
package burst_cfg_pkg;
  localparam logic [5:0] CFG_ADDR          = 6'h01;
  localparam logic [5:0] SETPOINT_ADDR     = 6'h0d;
  localparam int         SP_WR_BIT         = 6;
  localparam int         SP_OP_BIT         = 7;
  localparam logic [7:0] CFG_RESET         = 8'h04;
  localparam logic [1:0] BL_FIXED16        = 2'h0;
  localparam logic [1:0] BL_FIXED32        = 2'h1;
  localparam logic [1:0] BL_ON_THE_FLY     = 2'h2;
  localparam int         BL_LSB            = 0;
  localparam int         WR_PRE_BIT        = 2;
  localparam int         RD_PRE_BIT        = 3;
  localparam int         WR_LSB            = 4;
  localparam int         READ_POSTAMBLE_LEN_BIT        = 7;
  localparam logic [5:0] BURST16_BEATS     = 6'h10;
  localparam logic [5:0] BURST32_BEATS     = 6'h20;
  localparam int         CNT_W             = 6;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h3,
    ST_RECOV = 2'h2
  } state_t;
endpackage
`default_nettype wire

/* File: verilog/setpoint_if.sv */
// Interface: link between the core and its two-copy configuration store
`default_nettype none
interface setpoint_if;
  logic       wr_en;
  logic       wr_sel;
  logic [7:0] wr_data;
  logic       op_sel;
  logic [7:0] active_cfg;
  modport core  (output wr_en, output wr_sel, output wr_data, output op_sel,
                 input active_cfg);
  modport store (input wr_en, input wr_sel, input wr_data, input op_sel,
                 output active_cfg);
endinterface
`default_nettype wire

/* File: verilog/setpoint_store.sv */
// Two set-point copies of the burst and timing configuration, registered output
`default_nettype none
module setpoint_store (
  input  wire logic clk,
  input  wire logic rst_n,
  setpoint_if.store sp
);
  typedef struct packed {
    logic [1:0][7:0] copy;
    logic [7:0]      active;
  } store_t;

  store_t state_reg;
  store_t state_next;

  // Only the selected copy is written; the active copy feeds the core
  always_comb begin
    state_next = state_reg;
    if (sp.wr_en) begin
      state_next.copy[sp.wr_sel] = sp.wr_data;
    end
    state_next.active = state_next.copy[sp.op_sel];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= {burst_cfg_pkg::CFG_RESET, burst_cfg_pkg::CFG_RESET,
                    burst_cfg_pkg::CFG_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sp.active_cfg = state_reg.active;
endmodule
`default_nettype wire

/* File: verilog/burst_timing_config.sv */
// Burst and timing configuration register with read burst order generator
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Burst length field: 00 fixed 16 beats, 01 fixed 32, 10 per command, 11 reserved.
// - Write preamble bit must be 1 for a two-clock preamble; 0 is reserved.
// - Read preamble bit selects static preamble at 0 and toggling preamble at 1.
// - Write recovery field maps to 6,10,16,20,24,30,34,40 cycles before inner precharge.
// - Read postamble bit gives half a clock at 0 and one and a half clocks at 1.
// - In per-command mode the command's length bit picks 16 or 32 beats.
// - A mode write updates only the copy chosen by the set-point write select.
// - The device runs only from the copy chosen by the set-point operate select.
// - The two lowest column bits are taken as zero.
// - Reads start on 4-beat boundaries and wrap within 16, or within the half for 32.
// - This register sits at mode address 01h.
// - Reading this register back gives undefined data.
module burst_timing_config (
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  input  wire logic       MRW_VALID,
  input  wire logic [5:0] MRW_ADDR,
  input  wire logic [7:0] MRW_DATA,
  input  wire logic       MRR_VALID,
  input  wire logic [5:0] MRR_ADDR,
  input  wire logic       RD_CMD,
  input  wire logic       WR_CMD,
  input  wire logic       CMD_BL32,
  input  wire logic       CMD_AUTO_CLOSE_ROW,
  input  wire logic [9:0] CMD_COL,
  output logic [7:0]      MRR_DATA,
  output logic            MRR_VALID_OUT,
  output logic            BEAT_VALID,
  output logic [9:0]      BEAT_COL,
  output logic            LAST_BEAT,
  output logic            PRECHARGE_START,
  output logic            BUSY,
  output logic            WR_PREAMBLE_2CK,
  output logic            RD_PREAMBLE_TOGGLE,
  output logic            RD_POSTAMBLE_LONG,
  output logic            CFG_RESERVED_ERR
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Set-point store
  setpoint_if sp ();

  setpoint_store setpoint_store_inst (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .sp    (sp.store)
  );

  // Counter width, declared ahead of the function that sizes its result with it
  localparam int CNT_W_L = burst_cfg_pkg::CNT_W;

  // Write-recovery code to cycle count
  function automatic logic [CNT_W_L-1:0] recov_cycles(input logic [2:0] code);
    unique case (code)
      3'h0: recov_cycles = 6'h06;
      3'h1: recov_cycles = 6'h0a;
      3'h2: recov_cycles = 6'h10;
      3'h3: recov_cycles = 6'h14;
      3'h4: recov_cycles = 6'h18;
      3'h5: recov_cycles = 6'h1e;
      3'h6: recov_cycles = 6'h22;
      3'h7: recov_cycles = 6'h28;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    burst_cfg_pkg::state_t     st;
    logic                      sp_wr;
    logic                      sp_op;
    logic [CNT_W_L-1:0]        beat;
    logic [CNT_W_L-1:0]        len;
    logic [9:0]                base;
    logic                      auto_close;
    logic [CNT_W_L-1:0]        recov;
    logic [9:0]                col;
    logic                      beat_valid;
    logic                      last;
    logic                      pre_start;
    logic                      mrr_valid;
  } core_t;

  core_t state_reg;
  core_t state_next;
  logic [7:0] cfg;
  logic [1:0] bl_sel;
  logic [5:0] cur_len;
  logic [9:0] next_col;

  assign cfg    = sp.active_cfg;
  assign bl_sel = cfg[burst_cfg_pkg::BL_LSB +: 2];

  // Burst length for a new command; reserved code treated as 16 beats
  always_comb begin
    unique case (bl_sel)
      burst_cfg_pkg::BL_FIXED32:    cur_len = burst_cfg_pkg::BURST32_BEATS;
      burst_cfg_pkg::BL_ON_THE_FLY: cur_len = CMD_BL32 ? burst_cfg_pkg::BURST32_BEATS
                                                       : burst_cfg_pkg::BURST16_BEATS;
      default:                      cur_len = burst_cfg_pkg::BURST16_BEATS;
    endcase
  end

  // Read column order: wrap in 16 within the start half, then the other half
  always_comb begin
    logic [4:0] off;
    logic [3:0] low;
    off      = 5'h0;
    low      = state_reg.base[3:0] + state_reg.beat[3:0];
    off[3:0] = low;
    off[4]   = state_reg.base[4] ^ state_reg.beat[4];
    next_col = {state_reg.base[9:5], off};
  end

  // Sequencing of config writes, bursts and write recovery
  always_comb begin
    state_next            = state_reg;
    state_next.beat_valid = 1'b0;
    state_next.last       = 1'b0;
    state_next.pre_start  = 1'b0;
    state_next.mrr_valid  = MRR_VALID && (MRR_ADDR == burst_cfg_pkg::CFG_ADDR);
    if (MRW_VALID && MRW_ADDR == burst_cfg_pkg::SETPOINT_ADDR) begin
      state_next.sp_wr = MRW_DATA[burst_cfg_pkg::SP_WR_BIT];
      state_next.sp_op = MRW_DATA[burst_cfg_pkg::SP_OP_BIT];
    end
    unique case (state_reg.st)
      burst_cfg_pkg::ST_IDLE: begin
        if (RD_CMD) begin
          state_next.st   = burst_cfg_pkg::ST_READ;
          state_next.len  = cur_len;
          state_next.beat = '0;
          // 16-beat reads ignore column bit 4 except as the start offset
          state_next.base = {CMD_COL[9:2], 2'b00};
          if (cur_len == burst_cfg_pkg::BURST16_BEATS) begin
            state_next.base[9:4] = {CMD_COL[9:5], 1'b0};
            state_next.base[4]   = CMD_COL[4];
          end
          state_next.auto_close = CMD_AUTO_CLOSE_ROW;
        end else if (WR_CMD) begin
          state_next.st         = burst_cfg_pkg::ST_WRITE;
          state_next.len        = cur_len;
          state_next.beat       = '0;
          state_next.base       = {CMD_COL[9:2], 2'b00};
          state_next.auto_close = CMD_AUTO_CLOSE_ROW;
        end
      end
      burst_cfg_pkg::ST_READ: begin
        state_next.beat_valid = 1'b1;
        state_next.col        = next_col;
        state_next.beat       = state_reg.beat + 6'd1;
        if (state_reg.beat == state_reg.len - 6'd1) begin
          state_next.last = 1'b1;
          state_next.st   = burst_cfg_pkg::ST_IDLE;
        end
      end
      burst_cfg_pkg::ST_WRITE: begin
        // Write beats are counted only; write ordering lives elsewhere
        state_next.beat = state_reg.beat + 6'd1;
        if (state_reg.beat == state_reg.len - 6'd1) begin
          state_next.st    = state_reg.auto_close ? burst_cfg_pkg::ST_RECOV
                                                  : burst_cfg_pkg::ST_IDLE;
          state_next.recov = recov_cycles(cfg[burst_cfg_pkg::WR_LSB +: 3]);
        end
      end
      burst_cfg_pkg::ST_RECOV: begin
        state_next.recov = state_reg.recov - 6'd1;
        if (state_reg.recov == 6'd1) begin
          state_next.pre_start = 1'b1;
          state_next.st        = burst_cfg_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Config writes routed to the store by address
  assign sp.wr_en   = MRW_VALID && (MRW_ADDR == burst_cfg_pkg::CFG_ADDR);
  assign sp.wr_sel  = state_reg.sp_wr;
  assign sp.wr_data = MRW_DATA;
  assign sp.op_sel  = state_reg.sp_op;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Write-only register: read data is a fixed filler, not the stored value
  assign MRR_DATA           = 8'h00;
  assign MRR_VALID_OUT      = state_reg.mrr_valid;
  assign BEAT_VALID         = state_reg.beat_valid;
  assign BEAT_COL           = state_reg.col;
  assign LAST_BEAT          = state_reg.last;
  assign PRECHARGE_START    = state_reg.pre_start;
  assign BUSY               = state_reg.st != burst_cfg_pkg::ST_IDLE;
  assign WR_PREAMBLE_2CK    = cfg[burst_cfg_pkg::WR_PRE_BIT];
  assign RD_PREAMBLE_TOGGLE = cfg[burst_cfg_pkg::RD_PRE_BIT];
  assign RD_POSTAMBLE_LONG  = cfg[burst_cfg_pkg::READ_POSTAMBLE_LEN_BIT];
  // Flags a programmed reserved code so a misbehaving controller is visible
  assign CFG_RESERVED_ERR   = (bl_sel == 2'h3) || !cfg[burst_cfg_pkg::WR_PRE_BIT];
endmodule
`default_nettype wire

/* File: dv/burst_cfg_host.sv */
// Host controller model: mode register requests and column commands
`default_nettype none
module burst_cfg_host (
  input  wire logic  clk,
  output logic       mrw_valid,
  output logic [5:0] mrw_addr,
  output logic [7:0] mrw_data,
  output logic       mrr_valid,
  output logic [5:0] mrr_addr,
  output logic       rd_cmd,
  output logic       wr_cmd,
  output logic       cmd_bl32,
  output logic       cmd_auto_close_row,
  output logic [9:0] cmd_col
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle from time zero so nothing is taken during reset
  initial begin
    {mrw_valid, mrr_valid, rd_cmd, wr_cmd, cmd_bl32, cmd_auto_close_row} = 6'h00;
    {mrw_addr, mrr_addr, mrw_data, cmd_col} = 30'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Mode request held over one rising edge; released buses show the inverse
  task automatic mr(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    {mrw_valid, mrr_valid} = {wr, !wr};
    {mrw_addr, mrr_addr, mrw_data} = {a, a, d};
    @(negedge clk);
    {mrw_valid, mrr_valid} = 2'h0;
    {mrw_addr, mrr_addr, mrw_data} = ~{a, a, d};
  endtask
  // Column command; the caller chooses whether the row closes afterwards
  task automatic cmd(input logic wr, input logic [9:0] c, input logic b32, input logic ac);
    @(negedge clk);
    {rd_cmd, wr_cmd, cmd_auto_close_row} = {!wr, wr, ac};
    {cmd_bl32, cmd_col} = {b32, c};
    @(negedge clk);
    {rd_cmd, wr_cmd} = 2'h0;
    {cmd_bl32, cmd_auto_close_row, cmd_col} = ~{b32, ac, c};
  endtask
endmodule
`default_nettype wire

/* File: dv/burst_timing_config_assertions.sv */
// Port timing checker for the burst and timing configuration block
`default_nettype none
module burst_timing_config_assertions (
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  input wire logic       MRR_VALID,
  input wire logic [5:0] MRR_ADDR,
  input wire logic       RD_CMD,
  input wire logic       MRR_VALID_OUT,
  input wire logic [7:0] MRR_DATA,
  input wire logic       BEAT_VALID,
  input wire logic [9:0] BEAT_COL,
  input wire logic       LAST_BEAT,
  input wire logic       PRECHARGE_START,
  input wire logic       BUSY,
  input wire logic       WR_PREAMBLE_2CK,
  input wire logic       CFG_RESERVED_ERR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  //////////////////////////////////////////////////////////////////////////////
  // Read-back answers carry no real data, so the handshake and the fixed 00h filler are checked
  a_mrr_answer: assert property (MRR_VALID && MRR_ADDR == 6'h01 |=> MRR_VALID_OUT
    && MRR_DATA == 8'h00) else $error("Config read answer wrong");
  a_mrr_other: assert property (MRR_VALID && MRR_ADDR != 6'h01 |=> !MRR_VALID_OUT)
    else $error("Answer for foreign address");
  // Burst timing and order
  a_read_busy: assert property (RD_CMD && !BUSY |=> BUSY)
    else $error("No busy after read");
  a_first_beat: assert property (RD_CMD && !BUSY |-> ##2 BEAT_VALID && BEAT_COL[1:0] == 2'h0)
    else $error("First beat late or unaligned");
  a_beat_step: assert property (BEAT_VALID && !LAST_BEAT |=> BEAT_VALID
    && BEAT_COL[1:0] == $past(BEAT_COL[1:0]) + 2'h1 && $stable(BEAT_COL[9:5]))
    else $error("Beat order broken");
  a_last_end: assert property (LAST_BEAT |=> !BEAT_VALID && !BUSY)
    else $error("Burst runs past last beat");
  // Configuration flags and write recovery
  a_preamble_err: assert property (!WR_PREAMBLE_2CK |-> CFG_RESERVED_ERR)
    else $error("Reserved preamble not flagged");
  a_precharge_end: assert property (PRECHARGE_START |-> ##[0:1] !BUSY)
    else $error("Busy after precharge");
endmodule
bind burst_timing_config burst_timing_config_assertions burst_timing_config_assertions_inst (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .MRR_VALID(MRR_VALID), .MRR_ADDR(MRR_ADDR),
  .RD_CMD(RD_CMD), .MRR_VALID_OUT(MRR_VALID_OUT), .MRR_DATA(MRR_DATA),
  .BEAT_VALID(BEAT_VALID), .BEAT_COL(BEAT_COL), .LAST_BEAT(LAST_BEAT),
  .PRECHARGE_START(PRECHARGE_START), .BUSY(BUSY), .WR_PREAMBLE_2CK(WR_PREAMBLE_2CK),
  .CFG_RESERVED_ERR(CFG_RESERVED_ERR));
`default_nettype wire

/* File: dv/burst_timing_config_tb.sv */
// Self-checking bench for the burst and timing configuration block
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module burst_timing_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, mw, mv, rd, wr, b32, acr, mro, bv, lb, pst, busy, wp, rp, rl, er;
  logic [5:0] mwa, mra;
  logic [7:0] mwd, mrd;
  logic [9:0] col, bcol;
  int         miscompares = 0;
  int         checks_done = 0;
  int         write_recovery_cycles[8] = '{6, 10, 16, 20, 24, 30, 34, 40};
  // Clock at 40 MHz
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  burst_cfg_host burst_cfg_host_inst (.clk(clk), .mrw_valid(mw), .mrw_addr(mwa), .mrw_data(mwd),
    .mrr_valid(mv), .mrr_addr(mra), .rd_cmd(rd), .wr_cmd(wr), .cmd_bl32(b32),
    .cmd_auto_close_row(acr), .cmd_col(col));
  burst_timing_config burst_timing_config_inst (.REF_CLK(clk), .RESET_N(rst_n),
    .MRW_VALID(mw), .MRW_ADDR(mwa), .MRW_DATA(mwd), .MRR_VALID(mv), .MRR_ADDR(mra),
    .RD_CMD(rd), .WR_CMD(wr), .CMD_BL32(b32), .CMD_AUTO_CLOSE_ROW(acr), .CMD_COL(col),
    .MRR_DATA(mrd), .MRR_VALID_OUT(mro), .BEAT_VALID(bv), .BEAT_COL(bcol), .LAST_BEAT(lb),
    .PRECHARGE_START(pst), .BUSY(busy), .WR_PREAMBLE_2CK(wp), .RD_PREAMBLE_TOGGLE(rp),
    .RD_POSTAMBLE_LONG(rl), .CFG_RESERVED_ERR(er));
  //////////////////////////////////////////////////////////////////////////////
  // Verdict; also reached when a bounded wait runs out
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Settling gap covers the registered set-point store
  task automatic mwr(input logic [5:0] a, input logic [7:0] d);
    burst_cfg_host_inst.mr(1'b1, a, d);
    tick(3);
  endtask
  // Beats follow the wrap order: low nibble counts up, bit 4 flips half way for 32
  task automatic rd_burst(input logic [9:0] c, input logic l32, input int n);
    int k;
    logic [9:0] e;
    burst_cfg_host_inst.cmd(1'b0, c, l32, 1'b0);
    for (k = 0; k < 8 && bv !== 1'b1; k++) @(negedge clk);
    if (k == 8) begin
      miscompares++;
      stop_test();
    end
    for (int i = 0; i < n; i++) begin
      e = {c[9:5], ((n == 32) ? c[4] ^ i[4] : c[4]), 4'({c[3:2], 2'h0} + i[3:0])};
      `CHK({bv, lb, bcol}, {1'b1, i == n - 1, e})
      @(negedge clk);
    end
    `CHK(bv, 1'b0)
    `CHK(busy, 1'h0)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK({wp, rp, rl, er}, 4'h8)
    burst_cfg_host_inst.mr(1'b0, 6'h01, 8'h00);
    `CHK({mro, mrd}, 9'h100)
    burst_cfg_host_inst.mr(1'b0, 6'h0d, 8'h00);
    `CHK(mro, 1'b0)
    $display("t_reset done");
  endtask
  // Low column bits are ignored, so 2ee starts at 2ec
  task automatic t_read;
    rd_burst(10'h2ee, 1'b0, 16);
    $display("t_read done");
  endtask
  task automatic t_setpoint;
    mwr(6'h0d, 8'h40);
    mwr(6'h01, 8'h8d);
    `CHK({rp, rl}, 2'h0)
    mwr(6'h0d, 8'hc0);
    `CHK({wp, rp, rl}, 3'h7)
    rd_burst(10'h13c, 1'b0, 32);
    mwr(6'h01, 8'h06);
    rd_burst(10'h004, 1'b1, 32);
    rd_burst(10'h018, 1'b0, 16);
    $display("t_setpoint done");
  endtask
  task automatic t_reserved;
    mwr(6'h01, 8'h00);
    `CHK({wp, er}, 2'h1)
    mwr(6'h01, 8'h07);
    `CHK(er, 1'b1)
    $display("t_reserved done");
  endtask
  // Recovery compared against code 0, so fixed pipeline delay cancels out
  task automatic t_recov;
    int n0, n;
    for (int k = 0; k < 8; k++) begin
      mwr(6'h01, {1'b0, 3'(k), 4'h4});
      burst_cfg_host_inst.cmd(1'b1, 10'h000, 1'b0, 1'b1);
      for (n = 0; n < 200 && pst !== 1'b1; n++) @(negedge clk);
      if (n == 200) begin
        miscompares++;
        stop_test();
      end
      if (k == 0) n0 = n;
      // Sixteen write beats, then the programmed recovery count
      `CHK(n, 16 + write_recovery_cycles[k])
      `CHK(n - n0, write_recovery_cycles[k] - 6)
      tick(3);
    end
    $display("t_recov done");
  endtask
  // Without auto close the write ends after its beats and no precharge follows
  task automatic t_plain_write;
    int p;
    p = 0;
    burst_cfg_host_inst.cmd(1'h1, 10'h000, 1'h0, 1'h0);
    tick(15);
    `CHK(busy, 1'h1)
    tick(1);
    `CHK(busy, 1'h0)
    repeat (50) begin
      @(negedge clk);
      p += int'(pst);
    end
    `CHK(p, 0)
    $display("t_plain_write done");
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_read();
    t_setpoint();
    t_reserved();
    t_recov();
    t_plain_write();
    stop_test();
  end
endmodule
`default_nettype wire
